// file: hw/dac_filter_classg_control.sv
// DAC filter coefficient and supply-mode detector control, AXI4-Lite slave.
// Assumes a single-outstanding AXI4-Lite master on aclk and synchronous mclk.
//
// Functional notes
// - 19-bit coefficient split low 16, high 3
// - Last high register also holds filter enable
// - Clock select: 2MHz, MCLK/3, MCLK, off
// - Mode drops after hold time, 1ms steps
// - Threshold codes 1/16,1/8,3/16,1/4 full scale
// - Channel enable: bit0 left, bit1 right
// - One enable bit gates mode and hold timer; ms time base runs on
`timescale 1ns/1ns
module dac_filter_classg_control #(
   parameter int unsigned MCLK_TICKS_PER_MS = 12288,
   parameter int unsigned MCLK3_TICKS_PER_MS = 4096
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [supply_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [supply_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mclk,
   input wire supply_ctrl_pkg::dac_level_t dac_level,
   output supply_ctrl_pkg::filter_coef_t filter_coef,
   output logic supply_mode
);
   import supply_ctrl_pkg::*;

   logic [15:0] regs [NUM_REGS];
   logic aw_held;
   logic w_held;
   logic [7:0] aw_idx;
   logic [15:0] w_data;
   logic [1:0] w_strb;
   logic do_write;
   logic wr_hit;
   logic [2:0] wr_sel;
   logic [7:0] ar_idx;
   logic rd_hit;
   logic [15:0] rd_word;
   det_ctrl_t det_ctrl;
   logic det_tick;
   logic ms_tick;

   // ==========================================================
   // Write channel: address and data taken in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_idx <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_idx <= s_axi_awaddr[IDX_MSB:IDX_LSB];
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 16'h0000;
         w_strb <= 2'b00;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata[15:0];
         w_strb <= s_axi_wstrb[1:0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // Status is read-only, so a write to it is refused like a hole
   always_comb begin
      wr_hit = 1'b0;
      wr_sel = 3'h0;
      if (aw_idx >= IDX_A2_HIGH && aw_idx <= IDX_CTRL) begin
         wr_hit = 1'b1;
         wr_sel = 3'(aw_idx - IDX_A2_HIGH);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Register file; reserved bits are masked so they read as zero
   function automatic logic [15:0] write_mask(input int i);
      logic [15:0] m;
      m = MASK_UPPER;
      if (i == int'(IDX_CTRL - IDX_A2_HIGH)) begin
         m = MASK_CTRL;
      end else if (i == int'(IDX_B2_HIGH - IDX_A2_HIGH)) begin
         m = MASK_UPPER_EN;
      end else if (i % 2 == 1) begin
         m = MASK_LOW;
      end
      return m;
   endfunction

   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      localparam logic [15:0] WR_MASK = write_mask(g);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            regs[g] <= REG_RESET;
         end else if (do_write && wr_hit && wr_sel == 3'(g)) begin
            if (w_strb[0]) begin
               regs[g][7:0] <= w_data[7:0] & WR_MASK[7:0];
            end
            if (w_strb[1]) begin
               regs[g][15:8] <= w_data[15:8] & WR_MASK[15:8];
            end
         end
      end
   end

   // ==========================================================
   // Read channel; one answer at a time
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_idx = s_axi_araddr[IDX_MSB:IDX_LSB];

   always_comb begin
      rd_hit = 1'b1;
      rd_word = 16'h0000;
      if (ar_idx >= IDX_A2_HIGH && ar_idx <= IDX_CTRL) begin
         rd_word = regs[3'(ar_idx - IDX_A2_HIGH)];
      end else if (ar_idx == IDX_STATUS) begin
         rd_word[STAT_MODE_BIT] = supply_mode;
         rd_word[STAT_RUN_BIT] = (det_ctrl.clk_sel != SRC_OFF);
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_word};
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Coefficient assembly: low word bits 15:0, high word bits 18:16
   assign filter_coef.a2_upper = regs[0][UPPER_LSB +: UPPER_W];
   assign filter_coef.b0 = {regs[2][UPPER_LSB +: UPPER_W], regs[1]};
   assign filter_coef.b1 = {regs[4][UPPER_LSB +: UPPER_W], regs[3]};
   assign filter_coef.b2 = {regs[6][UPPER_LSB +: UPPER_W], regs[5]};
   assign filter_coef.path_en = regs[6][PATH_EN_BIT];

   // ==========================================================
   // Detector control fields
   assign det_ctrl.enable = regs[7][DET_EN_BIT];
   assign det_ctrl.chan_en = regs[7][CHAN_LSB +: 2];
   assign det_ctrl.threshold = regs[7][THR_LSB +: 2];
   assign det_ctrl.hold_ms = regs[7][HOLD_LSB +: 6];
   assign det_ctrl.clk_sel = det_clk_sel_t'(regs[7][CLKSEL_LSB +: 2]);

   detector_clock_select #(
      .MCLK_TICKS_PER_MS(MCLK_TICKS_PER_MS),
      .MCLK3_TICKS_PER_MS(MCLK3_TICKS_PER_MS)
   ) u_clk_sel (
      .aclk(aclk),
      .aresetn(aresetn),
      .mclk(mclk),
      .clk_sel(det_ctrl.clk_sel),
      .det_tick(det_tick),
      .ms_tick(ms_tick)
   );

   supply_mode_detector u_detector (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctrl(det_ctrl),
      .level(dac_level),
      .ms_tick(ms_tick),
      .supply_mode(supply_mode)
   );
endmodule

// file: common/supply_ctrl_pkg.sv
// Package: constants, register map and carrier types for the DAC filter
// coefficient and supply-mode detector control block.
// Assumes a 10 MHz register clock and 16-bit signed DAC level samples.
package supply_ctrl_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned INT_DET_HZ = 2_000_000;
   localparam int unsigned INT_DIV = CLK_HZ / INT_DET_HZ;
   localparam int unsigned MCLK_DIV = 3;
   localparam int unsigned MS_PER_S = 1_000;
   localparam int unsigned INT_TICKS_PER_MS = INT_DET_HZ / MS_PER_S;
   localparam int unsigned MCLK_HZ_DEFAULT = 12_288_000;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_A2_HIGH = 8'h44;
   localparam logic [7:0] IDX_B0_LOW = 8'h45;
   localparam logic [7:0] IDX_B0_HIGH = 8'h46;
   localparam logic [7:0] IDX_B1_LOW = 8'h47;
   localparam logic [7:0] IDX_B1_HIGH = 8'h48;
   localparam logic [7:0] IDX_B2_LOW = 8'h49;
   localparam logic [7:0] IDX_B2_HIGH = 8'h4a;
   localparam logic [7:0] IDX_CTRL = 8'h4b;
   localparam logic [7:0] IDX_STATUS = 8'h60;
   localparam int NUM_REGS = 8;
   localparam int ADDR_W = 12;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;

   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] MASK_LOW = 16'hffff;
   localparam logic [15:0] MASK_UPPER = 16'h0007;
   localparam logic [15:0] MASK_UPPER_EN = 16'h8007;
   localparam logic [15:0] MASK_CTRL = 16'h1fff;

   // ==========================================================
   // Field positions
   localparam int UPPER_LSB = 0;
   localparam int UPPER_W = 3;
   localparam int PATH_EN_BIT = 15;
   localparam int DET_EN_BIT = 0;
   localparam int CHAN_LSB = 1;
   localparam int THR_LSB = 3;
   localparam int HOLD_LSB = 5;
   localparam int CLKSEL_LSB = 11;
   localparam int STAT_MODE_BIT = 0;
   localparam int STAT_RUN_BIT = 1;

   // ==========================================================
   // Thresholds as magnitudes of a 16-bit signed full scale
   localparam logic [15:0] THR_1_16 = 16'h0800;
   localparam logic [15:0] THR_1_8 = 16'h1000;
   localparam logic [15:0] THR_3_16 = 16'h1800;
   localparam logic [15:0] THR_1_4 = 16'h2000;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'b00,
      SRC_MCLK_DIV3 = 2'b01,
      SRC_MCLK = 2'b10,
      SRC_OFF = 2'b11
   } det_clk_sel_t;

   typedef struct packed {
      det_clk_sel_t clk_sel;
      logic [5:0] hold_ms;
      logic [1:0] threshold;
      logic [1:0] chan_en;
      logic enable;
   } det_ctrl_t;

   typedef struct packed {
      logic path_en;
      logic [2:0] a2_upper;
      logic [18:0] b0;
      logic [18:0] b1;
      logic [18:0] b2;
   } filter_coef_t;

   typedef struct packed {
      logic [15:0] left;
      logic [15:0] right;
   } dac_level_t;

endpackage

// file: hw/detector_clock_select.sv
// Detector time base: picks the detector clock source and makes ms ticks.
// Assumes mclk is already synchronous to aclk and at most half its rate.
`timescale 1ns/1ns
module detector_clock_select #(
   parameter int unsigned MCLK_TICKS_PER_MS = 12288,
   parameter int unsigned MCLK3_TICKS_PER_MS = 4096
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic mclk,
   input wire supply_ctrl_pkg::det_clk_sel_t clk_sel,
   output logic det_tick,
   output logic ms_tick
);
   import supply_ctrl_pkg::*;

   logic mclk_q;
   logic mclk_rise;
   logic [2:0] int_cnt;
   logic [1:0] div3_cnt;
   logic [15:0] tick_cnt;
   logic [15:0] ms_limit;

   // ==========================================================
   // Source ticks
   assign mclk_rise = mclk & ~mclk_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mclk_q <= 1'b0;
      end else begin
         mclk_q <= mclk;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || int_cnt == 3'(INT_DIV - 1)) begin
         int_cnt <= 3'h0;
      end else begin
         int_cnt <= int_cnt + 3'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div3_cnt <= 2'h0;
      end else if (mclk_rise) begin
         div3_cnt <= (div3_cnt == 2'(MCLK_DIV - 1)) ? 2'h0 : div3_cnt + 2'h1;
      end
   end

   always_comb begin
      det_tick = 1'b0;
      ms_limit = 16'(INT_TICKS_PER_MS);
      case (clk_sel)
         SRC_INTERNAL: begin
            det_tick = (int_cnt == 3'(INT_DIV - 1));
            ms_limit = 16'(INT_TICKS_PER_MS);
         end
         SRC_MCLK_DIV3: begin
            det_tick = mclk_rise && (div3_cnt == 2'(MCLK_DIV - 1));
            ms_limit = 16'(MCLK3_TICKS_PER_MS);
         end
         SRC_MCLK: begin
            det_tick = mclk_rise;
            ms_limit = 16'(MCLK_TICKS_PER_MS);
         end
         default: begin
            det_tick = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Millisecond ticks; a stopped source freezes the count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= 16'h0000;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= 1'b0;
         if (det_tick) begin
            if (tick_cnt >= ms_limit - 16'h0001) begin
               tick_cnt <= 16'h0000;
               ms_tick <= 1'b1;
            end else begin
               tick_cnt <= tick_cnt + 16'h0001;
            end
         end
      end
   end
endmodule

// file: hw/supply_mode_detector.sv
// Supply-mode detector: level compare against threshold with ms hold.
// Assumes ms_tick is a one-cycle pulse once per detector millisecond.
`timescale 1ns/1ns
module supply_mode_detector (
   input wire logic aclk,
   input wire logic aresetn,
   input wire supply_ctrl_pkg::det_ctrl_t ctrl,
   input wire supply_ctrl_pkg::dac_level_t level,
   input wire logic ms_tick,
   output logic supply_mode
);
   import supply_ctrl_pkg::*;

   logic [15:0] mag_left;
   logic [15:0] mag_right;
   logic [15:0] thr;
   logic above;
   logic [5:0] below_ms;

   // ==========================================================
   // Compare; magnitude of the most negative sample is full scale
   assign mag_left = level.left[15] ? (~level.left + 16'h0001) : level.left;
   assign mag_right = level.right[15] ? (~level.right + 16'h0001) : level.right;

   always_comb begin
      case (ctrl.threshold)
         2'b00: thr = THR_1_16;
         2'b01: thr = THR_1_8;
         2'b10: thr = THR_3_16;
         default: thr = THR_1_4;
      endcase
   end

   assign above = (ctrl.chan_en[0] && mag_left > thr)
      || (ctrl.chan_en[1] && mag_right > thr);

   // ==========================================================
   // Hold timer; raise at once, drop after a full quiet hold time
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl.enable) begin
         supply_mode <= 1'b0;
         below_ms <= 6'h00;
      end else if (above) begin
         supply_mode <= 1'b1;
         below_ms <= 6'h00;
      end else if (supply_mode) begin
         // First quiet ms may be partial, so a nonzero hold waits for one more tick
         if (below_ms >= ctrl.hold_ms && (ms_tick || ctrl.hold_ms == 6'h00)) begin
            supply_mode <= 1'b0;
            below_ms <= 6'h00;
         end else if (ms_tick) begin
            below_ms <= below_ms + 6'h01;
         end
      end
   end
endmodule

// file: tb/dac_filter_classg_control_chk.sv
// Checker: bus answers and register-to-port relations of the control block.
// Assumes it is bound to dac_filter_classg_control and sees only its ports.
`timescale 1ns/1ns
module dac_filter_classg_control_chk
   import supply_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [supply_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire supply_ctrl_pkg::dac_level_t dac_level,
   input wire supply_ctrl_pkg::filter_coef_t filter_coef,
   input wire logic supply_mode
);
   // ==========================================
   // Helpers
   logic hs;
   logic [7:0] idx;
   logic [15:0] mag_l, mag_r;
   assign hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign idx = s_axi_awaddr[IDX_MSB:IDX_LSB];
   assign mag_l = dac_level.left[15] ? 16'h0000 - dac_level.left : dac_level.left;
   assign mag_r = dac_level.right[15] ? 16'h0000 - dac_level.right : dac_level.right;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================
   // Assertions
   AST_B_DUE: assert property (hs |-> ##[1:2] s_axi_bvalid)
      else $error("write answer missing");
   AST_R_DUE: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read accepted");
   AST_UNMAPPED: assert property (hs && (idx < IDX_A2_HIGH || idx > IDX_CTRL) |->
      ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR)) else $error("no error response");
   AST_B0_UPPER: assert property (hs && idx == IDX_B0_HIGH && s_axi_wstrb[0] |->
      ##2 filter_coef.b0[18:16] == $past(s_axi_wdata[2:0], 2)) else $error("b0 upper wrong");
   AST_B0_LOWER: assert property (hs && idx == IDX_B0_LOW && &s_axi_wstrb[1:0] |->
      ##2 filter_coef.b0[15:0] == $past(s_axi_wdata[15:0], 2)) else $error("b0 lower wrong");
   AST_PATH_EN: assert property (hs && idx == IDX_B2_HIGH && s_axi_wstrb[1] |->
      ##2 filter_coef.path_en == $past(s_axi_wdata[15], 2)) else $error("path enable wrong");
   AST_MODE_CAUSE: assert property ($rose(supply_mode) |->
      $past(mag_l > THR_1_16 || mag_r > THR_1_16)) else $error("mode rose without level");
endmodule
bind dac_filter_classg_control dac_filter_classg_control_chk u_chk (.aclk(aclk),
   .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .dac_level(dac_level), .filter_coef(filter_coef), .supply_mode(supply_mode));

// file: tb/tb.sv
// Testbench: register access, coefficient ports and supply-mode detector.
// Assumes the block is the only bus slave; mclk is made here at aclk/2.
`timescale 1ns/1ns
module tb;
   import supply_ctrl_pkg::*;
   // ==========================================
   // Signals
   logic aclk, aresetn, mclk, mode;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0] thr;
   logic [15:0] msk [8];
   dac_level_t lvl;
   filter_coef_t coef;
   int error_cnt, check_count, n;
   // Small ms counts keep the mclk runs short: 4 and 2 ticks per ms
   dac_filter_classg_control #(.MCLK_TICKS_PER_MS(4), .MCLK3_TICKS_PER_MS(2)) DUT (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .mclk(mclk), .dac_level(lvl), .filter_coef(coef), .supply_mode(mode));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      mclk <= ~mclk;
   end
   // ==========================================
   // Tasks
   task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %0t data %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %0t resp %b expected %b", $time, g, e);
      end
   endtask
   task automatic chk_flag(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %0t flag %b expected %b", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      if (error_cnt == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge aclk);
   endtask
   // Bus tasks start one edge late so strobes lowered last call never collide
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= {2'b00, a, 2'b00};
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      chk_flag(bvalid, 1'b1);
      chk_resp(bresp, er);
   endtask
   task automatic rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= {2'b00, a, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      chk_flag(rvalid, 1'b1);
      chk_resp(rresp, er);
      chk_data(rdata, ed);
   endtask
   task automatic ctl(input logic [1:0] c, input logic [5:0] h, input logic [1:0] t,
                      input logic [1:0] ch, input logic e);
      wr(IDX_CTRL, {3'b000, c, h, t, ch, e}, RESP_OKAY);
   endtask
   task automatic lv(input logic [15:0] l, input logic [15:0] r);
      @(posedge aclk);
      lvl <= '{left: l, right: r};
   endtask
   // Drop must land within hold .. hold+1 ms of going quiet; p is cycles per ms
   task automatic hold_chk(input logic [1:0] c, input logic [5:0] h, input int p);
      ctl(c, h, 2'b00, 2'b11, 1'b1);
      lv(16'h7fff, 16'h0000);
      idle(3);
      chk_flag(mode, 1'b1);
      lv(16'h0000, 16'h0000);
      n = 0;
      while (mode !== 1'b0 && n < (h + 1) * p + 10) begin
         @(posedge aclk);
         n++;
      end
      chk_flag(n >= h * p && n <= (h + 1) * p + 5, 1'b1);
   endtask
   // ==========================================
   // Tests
   initial begin
      msk = '{MASK_UPPER, MASK_LOW, MASK_UPPER, MASK_LOW, MASK_UPPER, MASK_LOW,
              MASK_UPPER_EN, MASK_CTRL};
      {aresetn, mclk, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, lvl} = '0;
      wstrb = 4'hf;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 8; i++) rdr(8'(IDX_A2_HIGH + i), 32'h0000_0000, RESP_OKAY);
      chk_flag(coef === '0 && mode === 1'b0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         wr(8'(IDX_A2_HIGH + i), 16'hffff, RESP_OKAY);
         rdr(8'(IDX_A2_HIGH + i), {16'h0000, msk[i]}, RESP_OKAY);
      end
      chk_flag(coef === {1'b1, 3'h7, 19'h7_ffff, 19'h7_ffff, 19'h7_ffff}, 1'b1);
      wr(IDX_B1_LOW, 16'h1234, RESP_OKAY);
      wr(IDX_B1_HIGH, 16'hfffd, RESP_OKAY);
      wr(IDX_B2_HIGH, 16'h0002, RESP_OKAY);
      chk_flag(coef.b1 === 19'h5_1234 && coef.b2 === 19'h2_ffff, 1'b1);
      chk_flag(coef.path_en, 1'b0);
      wr(8'h43, 16'h0001, RESP_SLVERR);
      wr(8'h4c, 16'h0001, RESP_SLVERR);
      wr(IDX_STATUS, 16'h0001, RESP_SLVERR);
      rdr(8'h4c, 32'h0000_0000, RESP_SLVERR);
      for (int t = 0; t < 4; t++) begin
         ctl(SRC_INTERNAL, 6'd0, 2'(t), 2'b01, 1'b1);
         thr = 16'(16'h0800 * (t + 1));
         lv(thr, 16'h0000);
         idle(3);
         chk_flag(mode, 1'b0);
         lv(16'h0000 - thr - 16'h0001, 16'h0000);
         idle(3);
         chk_flag(mode, 1'b1);
         lv(16'h0000, 16'h0000);
         idle(3);
         chk_flag(mode, 1'b0);
      end
      lv(16'h0000, 16'h7fff);
      idle(3);
      chk_flag(mode, 1'b0);
      ctl(SRC_INTERNAL, 6'd0, 2'b00, 2'b10, 1'b1);
      idle(3);
      chk_flag(mode, 1'b1);
      ctl(SRC_INTERNAL, 6'd0, 2'b00, 2'b10, 1'b0);
      idle(3);
      chk_flag(mode, 1'b0);
      hold_chk(SRC_MCLK, 6'd3, 8);
      hold_chk(SRC_MCLK_DIV3, 6'd3, 12);
      hold_chk(SRC_INTERNAL, 6'd2, 10000);
      rdr(IDX_STATUS, 32'h0000_0002, RESP_OKAY);
      ctl(SRC_OFF, 6'd1, 2'b00, 2'b11, 1'b1);
      lv(16'h7fff, 16'h0000);
      idle(3);
      lv(16'h0000, 16'h0000);
      idle(100);
      rdr(IDX_STATUS, 32'h0000_0001, RESP_OKAY);
      ctl(SRC_OFF, 6'd1, 2'b00, 2'b11, 1'b0);
      idle(3);
      chk_flag(mode, 1'b0);
      end_of_test();
   end
   initial begin
      #(100 * 60000);
      error_cnt++;
      end_of_test();
   end
endmodule
